/* rtl/serdes_ref_clock_config_map.vh */
// Offsets, field layouts, reset values, divider selects and management clock target of the reference clock block
`ifndef SERDES_REF_CLOCK_CONFIG_MAP_VH
`define SERDES_REF_CLOCK_CONFIG_MAP_VH
`define ADDR_W 4
`define A_CTRL 4'h0
`define A_PLLDIV 4'h1
`define A_CHDIV 4'h2
`define A_MGMT 4'h3
`define A_STATUS 4'h4
`define CTRL_FABRIC_SEL 0
`define CTRL_WIDTH_SEL 1
`define CTRL_COUPLING 2
`define CTRL_PWR_UP 3
`define CTRL_RST 4'h4
`define PLLDIV_RST 8'h21
`define CHDIV_RST 8'h00
`define MGMT_RST 4'h1
`define DIVSEL_ONE 2'h0
`define DIVSEL_TWO 2'h1
`define DIVSEL_FOUR 2'h2
`define MGMT_TARGET_MHZ 25
`endif

/* rtl/serdes_ref_clock_config.v */
// Reference clock selection, channel clock dividers and management clock divider
// Behaviour
// - Each channel TX and RX clock is the PLL clock divided by one, two or four; a select of 3 holds it low.
// - One reference input clocks both channels through the shared PLL.
// - Deserializer clock runs at half line rate; configuration chosen to get it.
// - Reference clock fed to the PLL is forwarded on a dedicated output.
// - Management logic clocked near 25 MHz by dividing reference by set divider.
// - Fabric reference source bypasses dedicated routing and feeds the PLL.
`include "serdes_ref_clock_config_map.vh"
module serdes_ref_clock_config (
    input wire clk_i,
    input wire resetn_i,
    input wire [`ADDR_W-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire ref_clock_in_i,
    input wire fabric_ref_clock_i,
    input wire pll_clock_i,
    output wire pll_ref_clock_o,
    output wire ref_clock_forward_o,
    output wire [3:0] tx_clock_o,
    output wire [3:0] rx_clock_o,
    output reg mgmt_clock_o,
    output wire internal_width_select_o,
    output wire [2:0] datapath_div_o,
    output wire [3:0] pll_feedback_divider_o,
    output wire [3:0] pll_reference_divider_o,
    output wire ref_input_coupling_option_o,
    output wire ref_clock_power_up_o
);
    reg [3:0] ctrl_q;
    reg [7:0] plldiv_q;
    reg [7:0] chdiv_q;
    reg [3:0] mgmt_div_q;
    reg [3:0] mgmt_cnt_q;
    reg [1:0] pll_cnt_q;
    reg [1:0] ref_sync_q;
    reg [1:0] pll_sync_q;
    reg [7:0] rdata_d;
    wire src_clk;
    wire [3:0] tap;
    // Clock path is a plain mux; glitches on a source change are why the tile is reset after it
    assign src_clk = ctrl_q[`CTRL_FABRIC_SEL] ? fabric_ref_clock_i : ref_clock_in_i;
    assign pll_ref_clock_o = src_clk;
    assign ref_clock_forward_o = src_clk;
    assign internal_width_select_o = ctrl_q[`CTRL_WIDTH_SEL];
    assign datapath_div_o = ctrl_q[`CTRL_WIDTH_SEL] ? 3'h5 : 3'h4;
    assign pll_feedback_divider_o = plldiv_q[7:4];
    assign pll_reference_divider_o = plldiv_q[3:0];
    assign ref_input_coupling_option_o = ctrl_q[`CTRL_COUPLING];
    assign ref_clock_power_up_o = ctrl_q[`CTRL_PWR_UP];
    // Divider taps on the sampled PLL clock: /1, /2, /4 (the /1 tap is the second synchronizer stage, pll_sync_q[1])
    assign tap = {1'b0, pll_cnt_q[1], pll_cnt_q[0], pll_sync_q[1]};
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : ch
            // Channel g: tx sel bits [4g+1:4g], rx sel bits [4g+3:4g+2]
            clock_tap_sel tx_sel_i (
                .tap_i(tap),
                .sel_i(chdiv_q[4*g+1:4*g]),
                .clk_o(tx_clock_o[2*g+1:2*g])
            );
            clock_tap_sel rx_sel_i (
                .tap_i(tap),
                .sel_i(chdiv_q[4*g+3:4*g+2]),
                .clk_o(rx_clock_o[2*g+1:2*g])
            );
        end
    endgenerate
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            ref_sync_q <= 2'h0;
            pll_sync_q <= 2'h0;
        end else begin
            ref_sync_q <= {ref_sync_q[0], src_clk};
            pll_sync_q <= {pll_sync_q[0], pll_clock_i};
        end
    end
    // Second-stage level is edge-detected against a third stage
    reg ref_prev_q;
    reg pll_prev_q;
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            ref_prev_q <= 1'b0;
            pll_prev_q <= 1'b0;
            pll_cnt_q <= 2'h0;
            mgmt_cnt_q <= 4'h0;
            mgmt_clock_o <= 1'b0;
        end else begin
            ref_prev_q <= ref_sync_q[1];
            pll_prev_q <= pll_sync_q[1];
            if (pll_sync_q[1] && !pll_prev_q)
                pll_cnt_q <= pll_cnt_q + 2'h1;
            if (mgmt_div_q <= 4'h1) begin
                // Divide by one (and 0) passes the sampled reference through, so it never stops
                mgmt_clock_o <= ref_sync_q[1];
                mgmt_cnt_q <= 4'h0;
            end else if (ref_sync_q[1] && !ref_prev_q) begin
                if (mgmt_cnt_q + 4'h1 >= mgmt_div_q) begin
                    mgmt_cnt_q <= 4'h0;
                    mgmt_clock_o <= 1'b1;
                end else begin
                    mgmt_cnt_q <= mgmt_cnt_q + 4'h1;
                    if (mgmt_cnt_q + 4'h1 >= (mgmt_div_q >> 1))
                        mgmt_clock_o <= 1'b0;
                end
            end
        end
    end
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_q <= `CTRL_RST;
            plldiv_q <= `PLLDIV_RST;
            chdiv_q <= `CHDIV_RST;
            mgmt_div_q <= `MGMT_RST;
        end else if (wr_i) begin
            case (addr_i)
                `A_CTRL: ctrl_q <= wdata_i[3:0];
                `A_PLLDIV: plldiv_q <= wdata_i;
                `A_CHDIV: chdiv_q <= wdata_i;
                `A_MGMT: mgmt_div_q <= wdata_i[3:0];
                default: ;
            endcase
        end
    end
    always @* begin
        rdata_d = 8'h00;
        case (addr_i)
            `A_CTRL: rdata_d = {4'h0, ctrl_q};
            `A_PLLDIV: rdata_d = plldiv_q;
            `A_CHDIV: rdata_d = chdiv_q;
            `A_MGMT: rdata_d = {4'h0, mgmt_div_q};
            `A_STATUS: rdata_d = {4'h0, mgmt_clock_o, pll_cnt_q, ref_sync_q[1]};
            default: rdata_d = 8'h00;
        endcase
    end
    always @(posedge clk_i) begin
        if (!resetn_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= rdata_d;
        else
            rdata_o <= 8'h00;
    end
endmodule // serdes_ref_clock_config

// One divider tap selector; serial and parallel copies share a tap so they never drift
module clock_tap_sel (
    input wire [3:0] tap_i,
    input wire [1:0] sel_i,
    output wire [1:0] clk_o
);
    assign clk_o = {2{tap_i[sel_i]}};
endmodule // clock_tap_sel

/* test/ref_clock_source.sv */
// Reference, fabric and PLL clock sources on the far side
module ref_clock_source (
    output logic ref_o = 0,
    output logic fabric_o = 0,
    output logic pll_o = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    always #200 ref_o = ~ref_o;
    always #300 fabric_o = ~fabric_o;
    always #150 pll_o = ~pll_o;
endmodule // ref_clock_source

/* test/serdes_ref_clock_config_sva.sv */
// Checker for the reference clock block
`include "serdes_ref_clock_config_map.vh"
module serdes_ref_clock_config_sva (
    input wire clk_i, resetn_i, wr_i, rd_i, ref_clock_in_i, fabric_ref_clock_i,
    input wire [3:0] addr_i, tx_clock_o, rx_clock_o,
    input wire [7:0] wdata_i, rdata_o,
    input wire pll_ref_clock_o, ref_clock_forward_o, internal_width_select_o,
    input wire ref_input_coupling_option_o, ref_clock_power_up_o,
    input wire [2:0] datapath_div_o,
    input wire [3:0] pll_feedback_divider_o, pll_reference_divider_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_fwd; ref_clock_forward_o == pll_ref_clock_o; endproperty
    a_fwd: assert property (p_fwd) else $error("forward differs");
    property p_src; pll_ref_clock_o == ref_clock_in_i || pll_ref_clock_o == fabric_ref_clock_i;
    endproperty
    a_src: assert property (p_src) else $error("bad source");
    property p_div; datapath_div_o == (internal_width_select_o ? 3'h5 : 3'h4); endproperty
    a_div: assert property (p_div) else $error("bad divide");
    property p_pair; tx_clock_o[0] == tx_clock_o[1] && tx_clock_o[2] == tx_clock_o[3]
        && rx_clock_o[0] == rx_clock_o[1] && rx_clock_o[2] == rx_clock_o[3]; endproperty
    a_pair: assert property (p_pair) else $error("pair differs");
    property p_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("data not 0");
    property p_wpll; wr_i && addr_i == `A_PLLDIV |=>
        {pll_feedback_divider_o, pll_reference_divider_o} == $past(wdata_i); endproperty
    a_wpll: assert property (p_wpll) else $error("pll write");
    property p_rpll; rd_i && addr_i == `A_PLLDIV |=>
        rdata_o == {pll_feedback_divider_o, pll_reference_divider_o}; endproperty
    a_rpll: assert property (p_rpll) else $error("pll read");
    property p_wctl; wr_i && addr_i == `A_CTRL |=> {ref_clock_power_up_o,
        ref_input_coupling_option_o, internal_width_select_o} == $past(wdata_i[3:1]); endproperty
    a_wctl: assert property (p_wctl) else $error("ctrl write");
endmodule // serdes_ref_clock_config_sva
bind serdes_ref_clock_config serdes_ref_clock_config_sva serdes_ref_clock_config_sva_i (.*);

/* test/serdes_ref_clock_config_tb.sv */
// Testbench for the reference clock block
`include "serdes_ref_clock_config_map.vh"
module serdes_ref_clock_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, mgmt_clock_o, ref_clock_in_i;
    logic fabric_ref_clock_i, pll_clock_i, pll_ref_clock_o, ref_clock_forward_o;
    logic internal_width_select_o, ref_input_coupling_option_o, ref_clock_power_up_o;
    logic [3:0] addr_i = 0, tx_clock_o, rx_clock_o, pll_feedback_divider_o, pll_reference_divider_o;
    logic [7:0] wdata_i = 0, rdata_o;
    logic [2:0] datapath_div_o;
    int errors = 0, samples_checked = 0;
    ref_clock_source ref_clock_source_i (.ref_o(ref_clock_in_i), .fabric_o(fabric_ref_clock_i),
        .pll_o(pll_clock_i));
    serdes_ref_clock_config serdes_ref_clock_config_i (.*);
    always #25 clk_i = ~clk_i;
    task chk(input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        addr_i <= a; wdata_i <= d; wr_i <= 1;
        @(posedge clk_i) wr_i <= 0;
        @(posedge clk_i);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        addr_i <= a; rd_i <= 1;
        @(posedge clk_i) rd_i <= 0;
        #1 chk(rdata_o, e);
    endtask
    function logic near(int a, b);
        return a <= b + 1 && b <= a + 1;
    endfunction
    task t_reset;
        rd(`A_CTRL, 8'h04); rd(`A_PLLDIV, 8'h21); rd(`A_CHDIV, 8'h00); rd(`A_MGMT, 8'h01);
        chk(ref_input_coupling_option_o, 1'h1);
        chk(datapath_div_o, 3'h4);
    endtask
    task t_pll;
        wr(`A_PLLDIV, 8'h52); wr(4'hf, 8'hff);
        rd(`A_PLLDIV, 8'h52); rd(4'hf, 8'h00);
        chk({pll_feedback_divider_o, pll_reference_divider_o}, 8'h52);
    endtask
    task t_ctrl;
        wr(`A_CTRL, 8'h0f);
        chk(datapath_div_o, 3'h5);
        repeat (8) @(posedge clk_i) #1 chk(ref_clock_forward_o, fabric_ref_clock_i);
        wr(`A_CTRL, 8'h04);
        repeat (8) @(posedge clk_i) #1 chk(pll_ref_clock_o, ref_clock_in_i);
    endtask
    task t_div;
        logic [4:0] v, p;
        int n[5];
        wr(`A_CHDIV, 8'h81); wr(`A_MGMT, 8'h03);
        p = 0; n = '{0, 0, 0, 0, 0};
        repeat (600) begin
            @(posedge clk_i) #1 v = {mgmt_clock_o, rx_clock_o[3], tx_clock_o[0], ref_clock_in_i,
                pll_clock_i};
            for (int i = 0; i < 5; i++) n[i] += v[i] & ~p[i];
            p = v;
        end
        chk(near(n[2], n[0] / 2), 1'h1);
        chk(near(n[3], n[0] / 4), 1'h1);
        chk(near(n[4], n[1] / 3), 1'h1);
    endtask
    task t_cfg;
        wr(`A_CTRL, 8'h0e);
        wr(`A_PLLDIV, 8'h21);
        wr(`A_CHDIV, 8'h04);
        wr(`A_MGMT, 8'h05);
        chk(ref_clock_power_up_o, 1'h1);
        chk(datapath_div_o, 3'h5);
        rd(`A_CHDIV, 8'h04);
        rd(`A_MGMT, 8'h05);
        resetn_i <= 0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1;
        rd(`A_MGMT, 8'h01);
        rd(`A_CTRL, 8'h04);
    endtask
    task end_sim;
        $display("errors %0d checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1;
        t_reset; t_pll; t_ctrl; t_div; t_cfg;
        end_sim;
    end
endmodule // serdes_ref_clock_config_tb
